// file: core/prps_top.sv
// pll reference select, phase compare and charge pump with apb registers
//
// Functional notes
// - codes select twelve reference rates or disable
// - power-on and clock-stop reset load 1111
// - chip enable low keeps rate code
// - disable code pulls down both oscillator inputs
// - disable code floats both error pins
// - up request when feedback lags reference
// - down request when feedback leads reference
// - no requests while pll disabled
// - requests go to pump and unlock detector
// - pump drives pins from current requests
// - low on up, high on down, else float
// - references divided from the crystal clock
`default_nettype none
module prps_top (
   // clock and resets
   input wire logic clk,
   input wire logic srst,
   input wire logic clk_stop_rst,
   // chip enable pin, low stops the pll
   input wire logic chip_en_in,
   // crystal clock and divided feedback, both asynchronous
   input wire logic xtal_clk_in,
   input wire logic fb_div_in,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // error out pins
   output logic error_out_hi_o,
   output logic error_out_hi_oe,
   output logic error_out_lo_o,
   output logic error_out_lo_oe,
   // oscillator input pulldowns
   output logic high_band_osc_pd,
   output logic low_band_osc_pd,
   // requests to unlock detector
   output logic unlock_up_n,
   output logic unlock_down_n
);
   import prps_pkg::*;

   typedef struct packed {
      logic [3:0] code;
      logic ce_s1;
      logic ce_s2;
      logic xt_s1;
      logic xt_s2;
      logic xt_s3;
      logic fb_s1;
      logic fb_s2;
      logic fb_s3;
      logic [31:0] rdata;
   } prps_top_st_t;

   prps_top_st_t st_q;
   prps_top_st_t st_d;
   prps_pd_if pd ();

   logic sel_rate;
   logic sel_stat;
   logic wr_rate;
   logic pll_on;

   assign sel_rate = (paddr == PRPS_ADDR_RATE);
   assign sel_stat = (paddr == PRPS_ADDR_STAT);
   assign wr_rate = psel && penable && pwrite && sel_rate;
   // chip enable low and the disable code both stop the loop
   assign pll_on = st_q.ce_s2 && (st_q.code != PRPS_CODE_OFF);

   always_comb begin
      st_d = st_q;
      // two flop synchronisers, edge taken from the second and third stage
      st_d.ce_s1 = chip_en_in;
      st_d.ce_s2 = st_q.ce_s1;
      st_d.xt_s1 = xtal_clk_in;
      st_d.xt_s2 = st_q.xt_s1;
      st_d.xt_s3 = st_q.xt_s2;
      st_d.fb_s1 = fb_div_in;
      st_d.fb_s2 = st_q.fb_s1;
      st_d.fb_s3 = st_q.fb_s2;
      if (wr_rate) begin
         // forbidden codes are stored as written, the reference then falls back to the slowest rate
         st_d.code = pwdata[PRPS_CODE_W-1:0];
      end
      if (clk_stop_rst) begin
         st_d.code = PRPS_CODE_RST;
      end
      // read data captured in the setup phase so it stands from a flop
      if (psel && !penable && !pwrite) begin
         st_d.rdata = '0;
         if (sel_rate) begin
            st_d.rdata[PRPS_CODE_W-1:0] = st_q.code;
         end
         if (sel_stat) begin
            st_d.rdata[PRPS_STAT_ON] = pll_on;
            st_d.rdata[PRPS_STAT_UP] = ~pd.up_n;
            st_d.rdata[PRPS_STAT_DN] = ~pd.down_n;
            st_d.rdata[PRPS_STAT_CE] = st_q.ce_s2;
         end
      end
   end

   // chip enable does not touch the code, so the old rate returns
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.code <= PRPS_CODE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // carrier
   assign pd.xtal_tick = st_q.xt_s2 && !st_q.xt_s3;
   assign pd.fb_pulse = st_q.fb_s2 && !st_q.fb_s3;
   assign pd.rate_code = st_q.code;
   assign pd.pll_on = pll_on;

   prps_ref_gen u_gen (
      .clk(clk),
      .srst(srst),
      .pd(pd.gen)
   );

   prps_phase_det u_det (
      .clk(clk),
      .srst(srst),
      .pd(pd.det)
   );

   // apb, zero wait states
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(sel_rate || (sel_stat && !pwrite));
   assign prdata = st_q.rdata;

   // charge pump: low on up, high on down, float when neither
   logic drive;
   assign drive = pll_on && (pd.up_n != pd.down_n);
   assign error_out_hi_oe = drive;
   assign error_out_lo_oe = drive;
   assign error_out_hi_o = drive && !pd.down_n;
   assign error_out_lo_o = drive && !pd.down_n;
   // chip enable low pulls the inputs down as well
   assign high_band_osc_pd = !pll_on;
   assign low_band_osc_pd = !pll_on;
   assign unlock_up_n = pd.up_n;
   assign unlock_down_n = pd.down_n;

   chk_reset_code: assert property (@(posedge clk)
      srst |=> st_q.code == PRPS_CODE_RST)
      else $error("power-on reset did not load disable code");
   chk_clkstop_code: assert property (@(posedge clk) disable iff (srst)
      clk_stop_rst |=> st_q.code == PRPS_CODE_RST && !pll_on)
      else $error("clock-stop reset did not disable pll");
   chk_ce_retain: assert property (@(posedge clk) disable iff (srst)
      (!st_q.ce_s2 && !wr_rate && !clk_stop_rst) |=> $stable(st_q.code))
      else $error("rate code changed on chip enable low");
   chk_write_code: assert property (@(posedge clk) disable iff (srst)
      (wr_rate && !clk_stop_rst) |=> st_q.code == $past(pwdata[3:0]))
      else $error("rate code write lost");
   chk_pulldown_off: assert property (@(posedge clk) disable iff (srst)
      st_q.code == PRPS_CODE_OFF |-> high_band_osc_pd && low_band_osc_pd)
      else $error("oscillator inputs not pulled down");
   chk_float_off: assert property (@(posedge clk) disable iff (srst)
      st_q.code == PRPS_CODE_OFF |-> !error_out_hi_oe && !error_out_lo_oe)
      else $error("error pins driven while disabled");
   chk_pump_low: assert property (@(posedge clk) disable iff (srst)
      (pll_on && !pd.up_n) |-> error_out_lo_oe && !error_out_lo_o && !error_out_hi_o)
      else $error("up request did not drive pins low");
   chk_pump_high: assert property (@(posedge clk) disable iff (srst)
      (pll_on && !pd.down_n) |-> error_out_hi_oe && error_out_hi_o && error_out_lo_o)
      else $error("down request did not drive pins high");
   chk_pump_float: assert property (@(posedge clk) disable iff (srst)
      (pd.up_n && pd.down_n) |-> !error_out_hi_oe && !error_out_lo_oe)
      else $error("pins driven without request");
   chk_unlock_route: assert property (@(posedge clk) disable iff (srst)
      unlock_up_n == pd.up_n && unlock_down_n == pd.down_n)
      else $error("unlock detector requests differ");
   chk_ce_stop: assert property (@(posedge clk) disable iff (srst)
      !st_q.ce_s2 |=> unlock_up_n && unlock_down_n)
      else $error("requests active with chip enable low");
endmodule
`default_nettype wire

// file: core/prps_pkg.sv
// constants and helpers for the reference select and phase compare block
`default_nettype none
package prps_pkg;
   // apb register map, printed offsets are word indexes
   localparam logic [11:0] PRPS_IDX_RATE = 12'h031;
   localparam logic [11:0] PRPS_IDX_STAT = 12'h032;
   localparam logic [11:0] PRPS_ADDR_RATE = {PRPS_IDX_RATE[9:0], 2'b00};
   localparam logic [11:0] PRPS_ADDR_STAT = {PRPS_IDX_STAT[9:0], 2'b00};
   localparam int PRPS_CODE_W = 4;
   localparam logic [3:0] PRPS_CODE_RST = 4'hf;
   localparam logic [3:0] PRPS_CODE_OFF = 4'hf;
   // status word fields
   localparam int PRPS_STAT_ON = 0;
   localparam int PRPS_STAT_UP = 1;
   localparam int PRPS_STAT_DN = 2;
   localparam int PRPS_STAT_CE = 3;
   // clocks and reference rates in hz
   localparam int PRPS_CLK_HZ = 20_000_000;
   localparam int PRPS_XTAL_HZ = 4_500_000;
   localparam int PRPS_CNT_W = 13;
   localparam int PRPS_REF_HZ [16] = '{1250, 2500, 5000, 10000, 6250, 12500, 25000, 50000,
      3000, 1000, 1000, 1000, 1000, 9000, 100000, 1000};
   typedef logic [PRPS_CNT_W-1:0] prps_cnt_t;

   // crystal ticks per reference period; unused codes fall back to the slowest rate
   function automatic prps_cnt_t prps_ref_div(input logic [3:0] code);
      int hz;
      hz = PRPS_REF_HZ[code];
      return prps_cnt_t'(PRPS_XTAL_HZ / hz);
   endfunction
endpackage
`default_nettype wire

// file: core/prps_pd_if.sv
// internal carrier between control, reference generator and phase detector
`default_nettype none
interface prps_pd_if;
   logic xtal_tick;
   logic [3:0] rate_code;
   logic pll_on;
   logic fb_pulse;
   logic ref_pulse;
   logic up_n;
   logic down_n;
   modport ctl (output xtal_tick, rate_code, pll_on, fb_pulse, input ref_pulse, up_n, down_n);
   modport gen (input xtal_tick, rate_code, pll_on, output ref_pulse);
   modport det (input ref_pulse, fb_pulse, pll_on, output up_n, down_n);
endinterface
`default_nettype wire

// file: core/prps_ref_gen.sv
// reference frequency divider from the crystal tick
`default_nettype none
module prps_ref_gen (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // carrier
   prps_pd_if.gen pd
);
   import prps_pkg::*;

   typedef struct packed {
      prps_cnt_t cnt;
      logic pulse;
   } prps_gen_st_t;

   prps_gen_st_t st_q;
   prps_gen_st_t st_d;
   prps_cnt_t div;

   always_comb begin
      div = prps_ref_div(pd.rate_code);
      st_d = st_q;
      st_d.pulse = 1'b0;
      if (!pd.pll_on) begin
         // stopped generator restarts a full period on enable
         st_d.cnt = '0;
      end else if (pd.xtal_tick) begin
         if (st_q.cnt >= div - prps_cnt_t'(1)) begin
            st_d.cnt = '0;
            st_d.pulse = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + prps_cnt_t'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pd.ref_pulse = st_q.pulse;

   // helper: ticks between pulses at a steady code
   prps_cnt_t gap_q;
   logic seen_q;
   logic [3:0] code_q;
   always_ff @(posedge clk) begin
      if (srst || !pd.pll_on) begin
         gap_q <= '0;
         seen_q <= 1'b0;
         code_q <= PRPS_CODE_OFF;
      end else begin
         code_q <= pd.rate_code;
         if (pd.ref_pulse) begin
            gap_q <= '0;
            seen_q <= 1'b1;
         end else if (pd.xtal_tick) begin
            gap_q <= gap_q + prps_cnt_t'(1);
         end
         if (code_q != pd.rate_code) begin
            seen_q <= 1'b0;
         end
      end
   end

   chk_ref_period_exact: assert property (@(posedge clk) disable iff (srst)
      (pd.ref_pulse && seen_q && code_q == pd.rate_code) |-> gap_q == div)
      else $error("reference period does not match selected rate");
   chk_ref_off_silent: assert property (@(posedge clk) disable iff (srst)
      !pd.pll_on |=> !pd.ref_pulse)
      else $error("reference pulse while pll disabled");
endmodule
`default_nettype wire

// file: core/prps_phase_det.sv
// phase frequency detector with active low up and down requests
`default_nettype none
module prps_phase_det (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // carrier
   prps_pd_if.det pd
);
   import prps_pkg::*;

   typedef struct packed {
      logic up;
      logic down;
   } prps_det_st_t;

   prps_det_st_t st_q;
   prps_det_st_t st_d;

   always_comb begin
      st_d.up = st_q.up | pd.ref_pulse;
      st_d.down = st_q.down | pd.fb_pulse;
      // both edges seen: in phase, drop both so the pins float
      if (st_d.up && st_d.down) begin
         st_d = '0;
      end
      if (!pd.pll_on) begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pd.up_n = ~st_q.up;
   assign pd.down_n = ~st_q.down;

   sequence s_ref_first;
      pd.pll_on && pd.ref_pulse && !pd.fb_pulse && pd.down_n;
   endsequence
   sequence s_fb_first;
      pd.pll_on && pd.fb_pulse && !pd.ref_pulse && pd.up_n;
   endsequence

   chk_up_on_lag: assert property (@(posedge clk) disable iff (srst)
      s_ref_first |=> !pd.up_n && pd.down_n)
      else $error("up request missing after lone reference edge");
   chk_down_on_lead: assert property (@(posedge clk) disable iff (srst)
      s_fb_first |=> !pd.down_n && pd.up_n)
      else $error("down request missing after lone feedback edge");
   chk_off_idle: assert property (@(posedge clk) disable iff (srst)
      !pd.pll_on |=> pd.up_n && pd.down_n)
      else $error("request active while pll disabled");
   chk_width_phase: assert property (@(posedge clk) disable iff (srst)
      (!pd.up_n && !pd.fb_pulse && pd.pll_on) |=> !pd.up_n)
      else $error("up request ended before feedback edge");
   chk_never_both: assert property (@(posedge clk) disable iff (srst)
      !(!pd.up_n && !pd.down_n))
      else $error("up and down requests active together");
endmodule
`default_nettype wire

// file: sim/prps_vco_model.sv
// loop filter and vco stand-in that makes the divided feedback edges
`default_nettype none
module prps_vco_model (
   // clock
   input wire logic clk,
   // control from bench
   input wire logic run,
   input wire logic [15:0] period,
   // pump pin
   input wire logic pump_o,
   input wire logic pump_oe,
   // divided feedback
   output logic fb_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   int trim = 0;
   initial fb_out = 1'h0;
   always @(posedge clk) begin
      if (!run) begin
         cnt <= 0;
         trim <= 0;
         fb_out <= 1'h0;
      end else begin
         cnt <= (cnt >= int'(period) + trim) ? 0 : cnt + 1;
         fb_out <= (cnt < (int'(period) + trim) / 2);
         // crude filter: a driven pin nudges the vco, a floating one holds it
         if (cnt == 0 && pump_oe) begin
            trim <= pump_o ? trim + 1 : trim - 1;
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for reference select and phase compare
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import prps_pkg::*;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic clk_stop_rst = 1'h0;
   logic chip_en_in = 1'h1;
   logic xtal_clk_in = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic run = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] period = 16'h0040;
   logic [31:0] prdata;
   logic pready, pslverr, hi_o, hi_oe, lo_o, lo_oe, pd_hi, pd_lo, up_n, dn_n, fb;
   int error_cnt = 0;
   int cmp_count = 0;
   initial begin
      forever #25 clk = ~clk;
   end
   // crystal is asynchronous to clk on purpose
   initial begin
      forever #111 xtal_clk_in = ~xtal_clk_in;
   end
   prps_top dut_u (.clk(clk), .srst(srst), .clk_stop_rst(clk_stop_rst), .chip_en_in(chip_en_in),
      .xtal_clk_in(xtal_clk_in), .fb_div_in(fb), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .error_out_hi_o(hi_o), .error_out_hi_oe(hi_oe), .error_out_lo_o(lo_o), .error_out_lo_oe(lo_oe),
      .high_band_osc_pd(pd_hi), .low_band_osc_pd(pd_lo), .unlock_up_n(up_n), .unlock_down_n(dn_n));
   prps_vco_model vco_u (.clk(clk), .run(run), .period(period), .pump_o(lo_o), .pump_oe(lo_oe), .fb_out(fb));
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) begin
         chk("pready", 32'h0000_0001, 32'h0000_0000);
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0000_0000, r, e);
      chk(what, exp, r);
      chk("slave_error", {31'h0000_0000, ee}, {31'h0000_0000, e});
   endtask
   task automatic wait_req(input logic want_up, input int bound, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((want_up ? up_n : dn_n) !== 1'h0 && n < bound);
      if ((want_up ? up_n : dn_n) !== 1'h0) begin
         chk("request_wait", 32'h0000_0000, 32'h0000_0001);
         wrap_up();
      end
   endtask
   task automatic t_reset;
      rd_chk("rate_reset", PRPS_ADDR_RATE, 32'h0000_000f, 1'h0);
      chk("osc_pulldown", 32'h0000_0003, {30'h0000_0000, pd_hi, pd_lo});
      chk("error_oe", 32'h0000_0000, {30'h0000_0000, hi_oe, lo_oe});
      chk("requests", 32'h0000_0003, {30'h0000_0000, up_n, dn_n});
   endtask
   task automatic t_codes;
      // forbidden codes 1001 to 1011 are never written
      logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd, 4'he, 4'hf};
      foreach (codes[i]) begin
         wr(PRPS_ADDR_RATE, {28'h000_0000, codes[i]});
         rd_chk("rate_code", PRPS_ADDR_RATE, {28'h000_0000, codes[i]}, 1'h0);
         rd_chk("status", PRPS_ADDR_STAT, {28'h000_0000, 1'h1, 2'h0, codes[i] != 4'hf}, 1'h0);
         chk("osc_pulldown", {30'h0000_0000, {2{codes[i] == 4'hf}}}, {30'h0000_0000, pd_hi, pd_lo});
      end
   endtask
   task automatic t_refs;
      logic [3:0] codes [3] = '{4'he, 4'h7, 4'hd};
      int hz [3] = '{100000, 50000, 9000};
      int n;
      int exp;
      foreach (codes[i]) begin
         exp = (PRPS_XTAL_HZ / hz[i]) * 222 / 50;
         wr(PRPS_ADDR_RATE, {28'h000_0000, codes[i]});
         wait_req(1'h1, 3000, n);
         chk("ref_period_ok", 32'h0000_0001, {31'h0000_0000, n >= exp - 6 && n <= exp + 10});
         chk("pins_up", 32'h0000_000a, {28'h000_0000, hi_oe, hi_o, lo_oe, lo_o});
         chk("down_idle", 32'h0000_0001, {31'h0000_0000, dn_n});
         rd_chk("status_up", PRPS_ADDR_STAT, 32'h0000_000b, 1'h0);
         wr(PRPS_ADDR_RATE, 32'h0000_000f);
         repeat (2) @(posedge clk);
         chk("off_idle", 32'h0000_0003, {28'h000_0000, hi_oe, lo_oe, up_n, dn_n});
      end
   endtask
   task automatic t_down;
      int n;
      wr(PRPS_ADDR_RATE, 32'h0000_000e);
      run <= 1'h1;
      wait_req(1'h0, 400, n);
      chk("pins_down", 32'h0000_000f, {28'h000_0000, hi_oe, hi_o, lo_oe, lo_o});
      chk("up_idle", 32'h0000_0001, {31'h0000_0000, up_n});
      // let about two and a half reference periods pass so period and request checks see traffic
      repeat (500) @(posedge clk);
      run <= 1'h0;
      wr(PRPS_ADDR_RATE, 32'h0000_000f);
   endtask
   task automatic t_resets;
      logic [31:0] r;
      logic e;
      wr(PRPS_ADDR_RATE, 32'h0000_0002);
      clk_stop_rst <= 1'h1;
      @(posedge clk);
      clk_stop_rst <= 1'h0;
      rd_chk("rate_clk_stop", PRPS_ADDR_RATE, 32'h0000_000f, 1'h0);
      wr(PRPS_ADDR_RATE, 32'h0000_0002);
      chip_en_in <= 1'h0;
      repeat (4) @(posedge clk);
      chk("ce_low_pins", 32'h0000_0003, {28'h000_0000, hi_oe, lo_oe, pd_hi, pd_lo});
      chip_en_in <= 1'h1;
      repeat (4) @(posedge clk);
      rd_chk("rate_kept", PRPS_ADDR_RATE, 32'h0000_0002, 1'h0);
      srst <= 1'h1;
      @(posedge clk);
      srst <= 1'h0;
      rd_chk("rate_srst", PRPS_ADDR_RATE, 32'h0000_000f, 1'h0);
      rd_chk("unmapped", 12'h100, 32'h0000_0000, 1'h1);
      // status is read only: a write is refused and leaves the code alone
      apb(1'h1, PRPS_ADDR_STAT, 32'h0000_0002, r, e);
      chk("status_write_err", 32'h0000_0001, {31'h0000_0000, e});
      rd_chk("rate_after_stat_wr", PRPS_ADDR_RATE, 32'h0000_000f, 1'h0);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      t_reset();
      t_codes();
      t_refs();
      t_down();
      t_resets();
      wrap_up();
   end
endmodule
`default_nettype wire
